// *** dma_defs.svh ***
// Constants shared by the four-channel transfer controller files.
`ifndef DMA_DEFS_SVH
`define DMA_DEFS_SVH

// ------------------------------------------------------------
// Widths and counts
// ------------------------------------------------------------
`define DMA_ADDR_W 24
`define DMA_DATA_W 16
`define DMA_CNT_W 14
`define DMA_PAD_W 16
`define DMA_SEL_W 8
`define DMA_NUM_CH 4
`define DMA_NUM_IRQ 256

// ------------------------------------------------------------
// Addressing and operating mode encodings
// ------------------------------------------------------------
`define AM_POST_INC 2'h0
`define AM_NO_INC 2'h1
`define AM_PERIPH 2'h2
`define MODE_ONE_SHOT 1'h1
`define MODE_PING_PONG 1'h1
`define STEP_BYTE 24'h000001
`define STEP_WORD 24'h000002

// ------------------------------------------------------------
// Request source select codes
// ------------------------------------------------------------
`define SEL_EXT_IRQ0 8'h00
`define SEL_CAP1 8'h01
`define SEL_CMP1 8'h02
`define SEL_CAP2 8'h05
`define SEL_CMP2 8'h06
`define SEL_TIMER_TWO 8'h07
`define SEL_TMR3 8'h08
`define SEL_SPI1 8'h0A
`define SEL_UART1_RX 8'h0B
`define SEL_UART1_TX 8'h0C
`define SEL_CONV 8'h0D
`define SEL_CMP3 8'h19
`define SEL_CMP4 8'h1A
`define SEL_TMR4 8'h1B
`define SEL_TIMER_FIVE 8'h1C
`define SEL_UART2_RX 8'h1E
`define SEL_UART2_TX 8'h1F
`define SEL_SPI2 8'h21
`define SEL_CAN_RX 8'h22
`define SEL_CAP3 8'h25
`define SEL_CAP4 8'h26
`define SEL_CAN_TX 8'h46

// ------------------------------------------------------------
// Peripheral data register addresses
// ------------------------------------------------------------
`define ADR_CAP1 16'h0144
`define ADR_CAP2 16'h014C
`define ADR_CAP3 16'h0154
`define ADR_CAP4 16'h015C
`define ADR_CMP1_PRI 16'h0906
`define ADR_CMP2_PRI 16'h0910
`define ADR_CMP2_SEC 16'h090E
`define ADR_CMP3_PRI 16'h091A
`define ADR_CMP4_PRI 16'h0924
`define ADR_SPI1 16'h0248
`define ADR_SPI2 16'h0268
`define ADR_UART1_RX 16'h0226
`define ADR_UART1_TX 16'h0224
`define ADR_UART2_RX 16'h0236
`define ADR_UART2_TX 16'h0234
`define ADR_CAN_RX 16'h0440
`define ADR_CAN_TX 16'h0442
`define ADR_CONV 16'h0300

`endif

// *** dma_pkg.sv ***
// Types shared by the four-channel transfer controller files.
`default_nettype none
`include "dma_defs.svh"

package dma_pkg;

  // Per-channel configuration, written by software.
  typedef struct packed {
    logic                   enable;
    logic                   size_byte;
    logic                   dir_ram_to_per;
    logic                   half;
    logic [1:0]             addressing_mode_select;
    logic [1:0]             mode;
    logic [`DMA_SEL_W-1:0]  request_source_select;
    logic [`DMA_ADDR_W-1:0] start_a;
    logic [`DMA_ADDR_W-1:0] start_b;
    logic [`DMA_PAD_W-1:0]  channel_peripheral_address;
    logic [`DMA_CNT_W-1:0]  count;
  } chan_cfg_type;

  // One request towards the data memory bus arbiter.
  typedef struct packed {
    logic                   req;
    logic                   we;
    logic                   size_byte;
    logic [`DMA_ADDR_W-1:0] addr;
    logic [`DMA_DATA_W-1:0] wdata;
  } mem_cmd_type;

  // What a request source offers as peripheral data register.
  typedef struct packed {
    logic                  rd_ok;
    logic                  wr_ok;
    logic [`DMA_PAD_W-1:0] addr;
  } periph_entry_type;

  // Running state of one channel.
  typedef struct packed {
    logic                   pending;
    logic                   force_on;
    logic                   halted;
    logic                   use_b;
    logic                   cfg_err;
    logic                   irq;
    logic [`DMA_ADDR_W-1:0] addr;
    logic [`DMA_CNT_W:0]    done_cnt;
  } chan_st_type;

  typedef enum logic [1:0] {
    ST_IDLE, ST_RD, ST_RWAIT, ST_WR
  } fsm_type;

endpackage
`default_nettype wire

// *** dma_buffer.sv ***
// Two-entry buffer between the read and the write half of a transfer.
`timescale 1ns/100ps
`default_nettype none
`include "dma_defs.svh"

module dma_buffer #(
  parameter int WIDTH = `DMA_DATA_W
) (
  // Clock and reset.
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  typedef struct packed {
    logic [1:0]       cnt;
    logic [WIDTH-1:0] head;
    logic [WIDTH-1:0] tail;
  } buf_type;

  buf_type q;
  buf_type d;
  logic    push;
  logic    pop;

  if (WIDTH < 1) begin : g_chk
    $error("Buffer width must be at least one.");
  end

  // Head is always the oldest word, so read data come from a register.
  assign in_ready  = (q.cnt != 2'h2);
  assign out_valid = (q.cnt != 2'h0);
  assign out_data  = q.head;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Next state of the two entries.
  always_comb begin
    d = q;
    case (q.cnt)
      2'h0: begin
        if (push) begin
          d.head = in_data;
          d.cnt  = 2'h1;
        end
      end
      2'h1: begin
        if (push && pop) begin
          d.head = in_data;
        end else if (push) begin
          d.tail = in_data;
          d.cnt  = 2'h2;
        end else if (pop) begin
          d.cnt = 2'h0;
        end
      end
      2'h2: begin
        if (pop) begin
          d.head = q.tail;
          d.cnt  = 2'h1;
        end
      end
      default: d.cnt = 2'h0;
    endcase
  end

  // State register.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule
`default_nettype wire

// *** dma_controller.sv ***
// Four-channel direct memory transfer controller, top level.
// ------------------------------------------------------------
// Summary of operation
// - Four independent channels, each serving its own selected peripheral.
// - Moves data between peripheral registers and any data space address.
// - All accesses pass a shared arbiter; grant may stall us.
// - Each channel moves one way; read and write need two channels.
// - Lowest channel number wins when several hold requests.
// - Channel raises an interrupt after moving a block.
// - Interrupt fires at half block or at full block, selectable.
// - Byte or word transfers per channel.
// - Post-increment, no-increment or peripheral-supplied RAM address.
// - Transfer starts by software force or peripheral request.
// - One-shot stops after a block (ping-pong one-shot after the B block); continuous restarts.
// - Ping-pong swaps start addresses A and B per block.
// - Any source selectable; timers trigger but have no data register.
// - Code zero selects external request zero, without data address.
// - Capture sources read buffers 0x0144 to 0x015C, step eight.
// - Compare sources are write only; unit two at 0x0910/0x090E.
// - Serial port done reads and writes one buffer address.
// - UART receive reads, transmit writes their data registers.
// - CAN receive code 00100010 reads address 0x0440.
// - CAN transmit code 01000110 writes address 0x0442.
// - Converter done code 00001101 reads from 0x0300.
// - Size bit set means byte, clear means word.
// - Direction set: RAM to peripheral; clear: peripheral to RAM.
// - Force is set only; cleared on completion or disable.
// - Mode 00 continuous, 01 one-shot, 10/11 same with ping-pong.
// ------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
`include "dma_defs.svh"

module dma_controller
  import dma_pkg::*;
#(
  parameter int NUM_CH  = `DMA_NUM_CH,
  parameter int NUM_IRQ = `DMA_NUM_IRQ
) (
  // Clock and reset.
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  // Channel configuration and software force pulses.
  input  wire chan_cfg_type [NUM_CH-1:0]    chan_cfg,
  input  wire logic [NUM_CH-1:0]            force_set,
  // Interrupt source lines and peripheral supplied addresses.
  input  wire logic [NUM_IRQ-1:0]           irq_lines,
  input  wire logic [NUM_CH-1:0][`DMA_ADDR_W-1:0] periph_addr,
  // Data memory bus arbiter port.
  output mem_cmd_type                       mem_cmd,
  input  wire logic                         mem_gnt,
  input  wire logic                         mem_rvalid,
  input  wire logic [`DMA_DATA_W-1:0]       mem_rdata,
  // Channel status.
  output logic [NUM_CH-1:0]                 block_irq,
  output logic [NUM_CH-1:0]                 force_active,
  output logic [NUM_CH-1:0]                 req_pending,
  output logic [NUM_CH-1:0]                 cfg_error,
  output logic [NUM_CH-1:0]                 buffer_b_active,
  output logic [((NUM_CH > 1) ? $clog2(NUM_CH) : 1)-1:0] active_channel
);

  localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
  localparam int EXT_W = `DMA_ADDR_W - `DMA_PAD_W;

  typedef struct packed {
    fsm_type                fsm;
    logic [CH_W-1:0]        ch;
    logic [`DMA_ADDR_W-1:0] dst;
    mem_cmd_type            cmd;
    chan_st_type [NUM_CH-1:0] chs;
  } ctl_type;

  ctl_type                            q;
  ctl_type                            d;
  periph_entry_type [NUM_CH-1:0]      lk;
  logic [NUM_CH-1:0]                  err;
  logic [NUM_CH-1:0]                  elig;
  logic [NUM_CH-1:0][`DMA_PAD_W-1:0]  pad_eff;
  logic [CH_W:0]                      pk;
  logic                               xfer_done;
  logic                               buf_in_valid;
  logic                               buf_in_ready;
  logic                               buf_out_valid;
  logic                               buf_out_ready;
  logic [`DMA_DATA_W-1:0]             buf_out_data;

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  if (NUM_CH < 1 || NUM_CH > 8) begin : g_chk_ch
    $error("Channel count must lie between one and eight.");
  end
  if (NUM_IRQ != (1 << `DMA_SEL_W)) begin : g_chk_irq
    $error("Source line count must match the select width.");
  end

  // ------------------------------------------------------------
  // Decoding functions
  // ------------------------------------------------------------

  // Data register and legal direction of each request source.
  function automatic periph_entry_type
      periph_lookup(input logic [`DMA_SEL_W-1:0] sel);
    periph_entry_type t;
    t = '0;
    case (sel)
      `SEL_EXT_IRQ0: t = '0;
      `SEL_TIMER_TWO, `SEL_TMR3, `SEL_TMR4, `SEL_TIMER_FIVE: t = '0;
      `SEL_CAP1: t = {2'h2, `ADR_CAP1};
      `SEL_CAP2: t = {2'h2, `ADR_CAP2};
      `SEL_CAP3: t = {2'h2, `ADR_CAP3};
      `SEL_CAP4: t = {2'h2, `ADR_CAP4};
      `SEL_CMP1: t = {2'h1, `ADR_CMP1_PRI};
      `SEL_CMP2: t = {2'h1, `ADR_CMP2_PRI};
      `SEL_CMP3: t = {2'h1, `ADR_CMP3_PRI};
      `SEL_CMP4: t = {2'h1, `ADR_CMP4_PRI};
      `SEL_SPI1: t = {2'h3, `ADR_SPI1};
      `SEL_SPI2: t = {2'h3, `ADR_SPI2};
      `SEL_UART1_RX: t = {2'h2, `ADR_UART1_RX};
      `SEL_UART1_TX: t = {2'h1, `ADR_UART1_TX};
      `SEL_UART2_RX: t = {2'h2, `ADR_UART2_RX};
      `SEL_UART2_TX: t = {2'h1, `ADR_UART2_TX};
      `SEL_CAN_RX: t = {2'h2, `ADR_CAN_RX};
      `SEL_CAN_TX: t = {2'h1, `ADR_CAN_TX};
      `SEL_CONV: t = {2'h2, `ADR_CONV};
      default: t = '0;
    endcase
    return t;
  endfunction

  // Lowest numbered set bit, with a found flag on top.
  function automatic logic [CH_W:0]
      pick_first(input logic [NUM_CH-1:0] v);
    logic [CH_W:0] r;
    r = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, CH_W'(i)};
      end
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // Per-channel decoding and status outputs
  // ------------------------------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    assign lk[c] = periph_lookup(chan_cfg[c].request_source_select);
    // A source with a data register refuses the wrong direction.
    assign err[c] = (lk[c].rd_ok | lk[c].wr_ok) &
                    (chan_cfg[c].dir_ram_to_per ? ~lk[c].wr_ok
                                                : ~lk[c].rd_ok);
    // A zero address field falls back to the source's own register.
    assign pad_eff[c] =
      (chan_cfg[c].channel_peripheral_address != '0) ?
      chan_cfg[c].channel_peripheral_address : lk[c].addr;
    assign elig[c] = chan_cfg[c].enable & ~q.chs[c].halted &
                     (q.chs[c].pending | q.chs[c].force_on) &
                     ~err[c];
    assign block_irq[c]       = q.chs[c].irq;
    assign force_active[c]    = q.chs[c].force_on;
    assign req_pending[c]     = q.chs[c].pending;
    assign cfg_error[c]       = q.chs[c].cfg_err;
    assign buffer_b_active[c] = q.chs[c].use_b;
  end

  assign pk             = pick_first(elig);
  assign xfer_done      = (q.fsm == ST_WR) & q.cmd.req & mem_gnt;
  assign buf_in_valid   = (q.fsm == ST_RWAIT) & mem_rvalid;
  assign buf_out_ready  = xfer_done;
  assign mem_cmd        = q.cmd;
  assign active_channel = q.ch;

  // ------------------------------------------------------------
  // Read data buffer
  // ------------------------------------------------------------
  dma_buffer #(
    .WIDTH (`DMA_DATA_W)
  ) u_buf (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (mem_rdata),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  // ------------------------------------------------------------
  // Next state: transfer sequencer and channel bookkeeping
  // ------------------------------------------------------------
  always_comb begin
    logic [`DMA_ADDR_W-1:0] ram;
    logic [`DMA_ADDR_W-1:0] per;
    logic [`DMA_CNT_W:0]    len;
    logic [`DMA_CNT_W:0]    nxt;
    ram = '0;
    per = '0;
    len = '0;
    nxt = '0;
    d   = q;
    case (q.fsm)
      // A new element starts only while the buffer can take it.
      ST_IDLE: begin
        if (pk[CH_W] && buf_in_ready) begin
          d.ch = pk[CH_W-1:0];
          if (chan_cfg[d.ch].addressing_mode_select == `AM_PERIPH) begin
            ram = periph_addr[d.ch];
          end else begin
            ram = q.chs[d.ch].addr;
          end
          per = {{EXT_W{1'b0}}, pad_eff[d.ch]};
          d.cmd.req       = 1'b1;
          d.cmd.we        = 1'b0;
          d.cmd.size_byte = chan_cfg[d.ch].size_byte;
          d.cmd.wdata     = '0;
          if (chan_cfg[d.ch].dir_ram_to_per) begin
            d.cmd.addr = ram;
            d.dst      = per;
          end else begin
            d.cmd.addr = per;
            d.dst      = ram;
          end
          d.fsm = ST_RD;
        end
      end
      // Hold the read until the arbiter grants it.
      ST_RD: begin
        if (mem_gnt) begin
          d.cmd.req = 1'b0;
          d.fsm     = ST_RWAIT;
        end
      end
      ST_RWAIT: begin
        if (mem_rvalid) begin
          d.fsm = ST_WR;
        end
      end
      // Issue the write from the buffer head, held until granted.
      ST_WR: begin
        if (!q.cmd.req) begin
          if (buf_out_valid) begin
            d.cmd.req   = 1'b1;
            d.cmd.we    = 1'b1;
            d.cmd.addr  = q.dst;
            d.cmd.wdata = buf_out_data;
          end
        end else if (mem_gnt) begin
          d.cmd.req = 1'b0;
          d.fsm     = ST_IDLE;
        end
      end
      default: d.fsm = ST_IDLE;
    endcase

    for (int c = 0; c < NUM_CH; c++) begin
      d.chs[c].irq     = 1'b0;
      d.chs[c].cfg_err = err[c];
      len = {1'b0, chan_cfg[c].count} + {{`DMA_CNT_W{1'b0}}, 1'b1};
      nxt = q.chs[c].done_cnt + {{`DMA_CNT_W{1'b0}}, 1'b1};
      // Completion retires the request and advances the channel.
      if (xfer_done && q.ch == CH_W'(c)) begin
        d.chs[c].pending  = 1'b0;
        d.chs[c].force_on = 1'b0;
        if (chan_cfg[c].addressing_mode_select == `AM_POST_INC) begin
          d.chs[c].addr = q.chs[c].addr +
            (chan_cfg[c].size_byte ? `STEP_BYTE : `STEP_WORD);
        end
        if (chan_cfg[c].half && nxt == {1'b0, len[`DMA_CNT_W:1]}) begin
          d.chs[c].irq = 1'b1;
        end
        if (nxt == len) begin
          d.chs[c].irq      = ~chan_cfg[c].half;
          d.chs[c].done_cnt = '0;
          if (chan_cfg[c].mode[1] == `MODE_PING_PONG) begin
            d.chs[c].use_b = ~q.chs[c].use_b;
          end
          d.chs[c].addr = d.chs[c].use_b ? chan_cfg[c].start_b
                                         : chan_cfg[c].start_a;
          // One-shot ping-pong stops after the B block.
          if (chan_cfg[c].mode[0] == `MODE_ONE_SHOT &&
              (chan_cfg[c].mode[1] != `MODE_PING_PONG ||
               q.chs[c].use_b)) begin
            d.chs[c].halted = 1'b1;
          end
        end else begin
          d.chs[c].done_cnt = nxt;
        end
      end
      // New events win over the completion clear.
      if (irq_lines[chan_cfg[c].request_source_select]) begin
        d.chs[c].pending = 1'b1;
      end
      if (force_set[c]) begin
        d.chs[c].force_on = 1'b1;
      end
      // A disabled channel forgets everything and rearms at A.
      if (!chan_cfg[c].enable) begin
        d.chs[c].pending  = 1'b0;
        d.chs[c].force_on = 1'b0;
        d.chs[c].halted   = 1'b0;
        d.chs[c].use_b    = 1'b0;
        d.chs[c].done_cnt = '0;
        d.chs[c].addr     = chan_cfg[c].start_a;
      end
    end
  end

  // State register.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic [NUM_CH-1:0] lower;
  assign lower = (NUM_CH'(1) << q.ch) - NUM_CH'(1);

  sequence s_rd_done;
    q.fsm == ST_RWAIT && mem_rvalid;
  endsequence
  sequence s_wr_issue;
    q.fsm == ST_WR ##1 (q.cmd.req && q.cmd.we && q.cmd.addr == q.dst);
  endsequence

  chk_bus_hold: assert property (
    q.cmd.req && !mem_gnt |=> q.cmd.req && $stable(q.cmd.addr))
    else $error("Request dropped or moved without grant.");
  chk_read_write: assert property (s_rd_done |=> s_wr_issue)
    else $error("Read data not written out.");
  chk_prio_pick: assert property (
    q.fsm == ST_IDLE ##1 q.fsm == ST_RD |-> ($past(elig) & lower) == '0)
    else $error("Lower channel skipped.");
  chk_dir_source: assert property (
    $rose(q.cmd.req) && !q.cmd.we |->
      (chan_cfg[q.ch].dir_ram_to_per ? q.dst : q.cmd.addr) ==
      {{EXT_W{1'b0}}, pad_eff[q.ch]})
    else $error("Peripheral side of the transfer is wrong.");

  for (genvar c = 0; c < NUM_CH; c++) begin : g_chk
    chk_force_drop: assert property (
      q.chs[c].force_on && !chan_cfg[c].enable |=> !q.chs[c].force_on)
      else $error("Force kept on a disabled channel.");
    chk_pending_kept: assert property (
      q.chs[c].pending && chan_cfg[c].enable &&
      !(xfer_done && q.ch == CH_W'(c)) |=> q.chs[c].pending)
      else $error("Pending request lost.");
    chk_full_irq: assert property (
      xfer_done && q.ch == CH_W'(c) && chan_cfg[c].enable &&
      !chan_cfg[c].half &&
      q.chs[c].done_cnt == {1'b0, chan_cfg[c].count}
      |=> q.chs[c].irq ##1 !q.chs[c].irq)
      else $error("Full block interrupt missing.");
    chk_addr_step: assert property (
      xfer_done && q.ch == CH_W'(c) && chan_cfg[c].enable &&
      chan_cfg[c].addressing_mode_select == `AM_POST_INC &&
      q.chs[c].done_cnt != {1'b0, chan_cfg[c].count}
      |=> q.chs[c].addr == $past(q.chs[c].addr) +
          ($past(chan_cfg[c].size_byte) ? `STEP_BYTE : `STEP_WORD))
      else $error("Post increment step wrong.");
  end

endmodule
`default_nettype wire

// *** dma_mem_model.sv ***
// Arbiter and SRAM model on the far side of the transfer controller.
`timescale 1ns/100ps
`default_nettype none
`include "dma_defs.svh"
module dma_mem_model
  import dma_pkg::*;
(
  // Clock and reset.
  input  wire logic               core_clk,
  input  wire logic               rst,
  // Data memory bus.
  input  wire mem_cmd_type        mem_cmd,
  output logic                    mem_gnt,
  output logic                    mem_rvalid,
  output logic [`DMA_DATA_W-1:0]  mem_rdata
);
  logic rd;
  // A read is taken on an edge where request and grant are both high.
  assign rd = mem_cmd.req & mem_gnt & ~mem_cmd.we;
  // Grants at random, as a busy CPU would; reads answer one cycle later.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem_gnt <= 1'h0;
      mem_rvalid <= 1'h0;
      mem_rdata <= 16'h0000;
    end else begin
      mem_gnt <= 1'($urandom);
      mem_rvalid <= rd;
      mem_rdata <= rd ? mem_cmd.addr[15:0] ^ 16'h5A5A : ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

// *** four_channel_dma_controller_test.sv ***
// Self-checking bench for the four-channel transfer controller.
`timescale 1ns/100ps
`default_nettype none
module four_channel_dma_controller_test;
  import dma_pkg::*;
  logic core_clk, rst, mem_gnt, mem_rvalid;
  chan_cfg_type [3:0] chan_cfg;
  logic [3:0] force_set, block_irq, force_active, req_pending;
  logic [3:0] cfg_error, buffer_b_active;
  logic [255:0] irq_lines;
  logic [3:0][23:0] periph_addr;
  mem_cmd_type mem_cmd;
  logic [15:0] mem_rdata;
  logic [1:0] active_channel;
  logic [23:0] ra, last;
  logic [31:0] e;
  int n_mismatch, n_checks, cyc, bytes;
  logic [31:0] tbl [22] = '{32'h0022_0440, 32'h0001_0144, 32'h0005_014C,
    32'h0025_0154, 32'h0026_015C, 32'h000A_0248, 32'h0021_0268,
    32'h000B_0226, 32'h001E_0236, 32'h000D_0300, 32'h0106_0910,
    32'h010C_0224, 32'h011F_0234, 32'h0146_0442, 32'h010A_0248,
    32'h0102_0906, 32'h0119_091A, 32'h011A_0924, 32'h0207_1234,
    32'h031C_2000, 32'h0200_2004, 32'h0306_090E};
  dma_controller dut (.core_clk(core_clk), .rst(rst), .chan_cfg(chan_cfg),
    .force_set(force_set), .irq_lines(irq_lines), .periph_addr(periph_addr),
    .mem_cmd(mem_cmd), .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid),
    .mem_rdata(mem_rdata), .block_irq(block_irq), .force_active(force_active),
    .req_pending(req_pending), .cfg_error(cfg_error),
    .buffer_b_active(buffer_b_active), .active_channel(active_channel));
  dma_mem_model mem (.core_clk(core_clk), .rst(rst), .mem_cmd(mem_cmd),
    .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
  // Clock, and a ceiling on the run length.
  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  // Start address A of a channel; B lies 0x800 above it.
  function automatic logic [23:0] sa(int ch);
    return ra + 24'(ch) * 24'h001000;
  endfunction
  task automatic check(string w, logic [23:0] x, logic [23:0] g);
    n_checks++;
    if (x !== g) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", w, x, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Disables the channel for a cycle so it rearms, then enables it.
  task automatic setup(int ch, logic [7:0] sel, logic dir, logic sz,
      logic [1:0] am, logic [1:0] md, logic [13:0] cnt, logic hf,
      logic [15:0] pad);
    chan_cfg[ch] <= '{1'h0, sz, dir, hf, am, md, sel, sa(ch),
      sa(ch) + 24'h000800, pad, cnt};
    @(posedge core_clk);
    chan_cfg[ch].enable <= 1'h1;
    @(posedge core_clk);
  endtask
  // A negative source gives a software force instead of a request line.
  task automatic kick(int ch, int sel);
    if (sel < 0) force_set[ch] <= 1'h1;
    else irq_lines[sel] <= 1'h1;
    @(posedge core_clk);
    force_set <= 4'h0;
    irq_lines <= '0;
  endtask
  // Waits for the next granted access and compares it.
  task automatic access(int ch, logic we, logic [23:0] adr);
    int k;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (!(mem_cmd.req === 1'h1 && mem_gnt === 1'h1) && k < 300);
    check("write enable", we, mem_cmd.we);
    check("address", adr, mem_cmd.addr);
    check("size", 24'(bytes), 24'(mem_cmd.size_byte));
    if (!we) last = adr;
    else if (bytes == 0) check("data", last[15:0] ^ 16'h5A5A, mem_cmd.wdata);
    if (we) check("channel", 24'(ch), active_channel);
  endtask
  task automatic move(int ch, logic [23:0] rd, logic [23:0] wr, logic irq);
    access(ch, 1'h0, rd);
    access(ch, 1'h1, wr);
    @(posedge core_clk);
    check("block irq", irq, block_irq[ch]);
  endtask
  initial begin
    void'($urandom(147));
    rst = 1'h1;
    chan_cfg = '0;
    force_set = 4'h0;
    irq_lines = '0;
    ra = 24'($urandom) & 24'hFF0000;
    for (int c = 0; c < 4; c++) periph_addr[c] = 24'($urandom) & 24'hFFFFFE;
    repeat (10) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    foreach (tbl[i]) begin
      e = tbl[i];
      setup(0, e[23:16], e[24], 0, 2'h0, 2'h0, 14'h0003, 0,
        e[25] ? e[15:0] : 16'h0000);
      kick(0, int'(e[23:16]));
      if (e[24]) move(0, sa(0), {8'h00, e[15:0]}, 0);
      else move(0, {8'h00, e[15:0]}, sa(0), 0);
    end
    $display("source table done");
    setup(0, 8'h0A, 0, 0, 2'h0, 2'h1, 14'h0001, 0, 16'h0000);
    kick(0, -1);
    move(0, 24'h000248, sa(0), 0);
    check("force clear", 0, force_active[0]);
    kick(0, -1);
    move(0, 24'h000248, sa(0) + 24'h000002, 1);
    kick(0, -1);
    repeat (30) @(posedge core_clk);
    check("halted", 1, force_active[0] & ~mem_cmd.req);
    chan_cfg[0].enable <= 1'h0;
    repeat (2) @(posedge core_clk);
    check("force off", 0, force_active[0]);
    $display("one-shot force done");
    bytes = 1;
    setup(0, 8'h0B, 0, 1, 2'h0, 2'h0, 14'h0003, 0, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      kick(0, 8'h0B);
      move(0, 24'h000226, sa(0) + 24'(i), 0);
    end
    bytes = 0;
    setup(0, 8'h0D, 0, 0, 2'h0, 2'h0, 14'h0003, 1, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      kick(0, -1);
      move(0, 24'h000300, sa(0) + 24'(2 * i), i == 1);
    end
    setup(1, 8'h0D, 0, 0, 2'h1, 2'h0, 14'h0003, 0, 16'h0000);
    setup(2, 8'h0D, 0, 0, 2'h2, 2'h0, 14'h0003, 0, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      kick(1, -1);
      move(1, 24'h000300, sa(1), 0);
      kick(2, -1);
      move(2, 24'h000300, periph_addr[2], 0);
    end
    setup(3, 8'h06, 0, 0, 2'h0, 2'h0, 14'h0003, 0, 16'h0000);
    repeat (2) @(posedge core_clk);
    check("config error", 1, cfg_error[3]);
    $display("size, half and addressing done");
    for (int m = 2; m < 4; m++) begin
      setup(3, 8'h0C, 1, 0, 2'h0, 2'(m), 14'h0000, 0, 16'h0000);
      for (int j = 0; j < 3; j++) begin
        kick(3, 8'h0C);
        if (m == 3 && j == 2) begin
          repeat (30) @(posedge core_clk);
          check("halted pair", 1, req_pending[3] & ~mem_cmd.req);
        end else begin
          move(3, sa(3) + 24'(j % 2) * 24'h000800, 24'h000224, 1);
          check("buffer b", j % 2 == 0, buffer_b_active[3]);
        end
      end
    end
    $display("ping-pong done");
    setup(1, 8'h0B, 0, 0, 2'h0, 2'h0, 14'h0003, 0, 16'h0000);
    setup(2, 8'h0D, 0, 0, 2'h0, 2'h0, 14'h0003, 0, 16'h0000);
    // Channel zero still listens to source 0x0D, so it is switched off.
    chan_cfg[0].enable <= 1'h0;
    irq_lines[8'h0D] <= 1'h1;
    kick(1, 8'h0B);
    @(posedge core_clk);
    check("pending", 2'h3, req_pending[2:1]);
    move(1, 24'h000226, sa(1), 0);
    check("still pending", 1, req_pending[2]);
    move(2, 24'h000300, sa(2), 0);
    $display("priority done");
    summarize();
  end
endmodule
`default_nettype wire
